//--- common/dsm_pkg.sv
// Constants, slot classes and helpers for the DS3 to STS-1 envelope mapper
package dsm_pkg;

  // ***************************************************************
  // Envelope geometry, slot indices count from the first POH bit
  // ***************************************************************
  localparam int unsigned SLOT_W = 10;
  localparam logic [3:0] ROW_LAST = 4'h8;
  localparam logic [3:0] ROWS = 4'h9;
  localparam logic [9:0] POH_BITS = 10'h008;
  localparam logic [9:0] LEAD_FIX_END = 10'h03b;
  localparam logic [9:0] CTRL_STRIDE = 10'h07d;
  localparam logic [9:0] CTRL_AREA_END = 10'h2ac;
  localparam logic [9:0] SO_POS = 10'h2ae;
  localparam logic [9:0] TAIL_DATA_POS = 10'h2af;
  localparam logic [9:0] SLOT_LAST = 10'h2b7;

  // ***************************************************************
  // Bit counts per row and per envelope
  // ***************************************************************
  localparam logic [9:0] FIX_PER_ROW = 10'h03b;
  localparam logic [9:0] DATA_PER_ROW = 10'h26d;
  localparam logic [9:0] CTRL_PER_ROW = 10'h005;
  localparam logic [9:0] SO_PER_ROW = 10'h001;
  localparam logic [9:0] OH_PER_ROW = 10'h002;
  localparam logic [2:0] SO_MIN = 3'h2;
  localparam logic [2:0] SO_NOM = 3'h3;
  localparam logic [2:0] SO_MAX = 3'h4;
  localparam logic [2:0] CTRL_VOTE = 3'h3;
  localparam logic [12:0] DS3_NOM_BITS = 13'h15d8;
  localparam logic FIX_VALUE = 1'b0;

  typedef enum logic [2:0] {
    CLS_POH = 3'b000,
    CLS_FIX = 3'b001,
    CLS_DATA = 3'b010,
    CLS_CTRL = 3'b011,
    CLS_SO = 3'b100,
    CLS_OH = 3'b101
  } dsm_class_t;

  // Bit type of a slot within a row
  function automatic dsm_class_t dsm_slot_class(input logic [9:0] s);
    logic [9:0] off;
    off = s - LEAD_FIX_END;
    if (s < POH_BITS)
      return CLS_POH;
    else if (s < LEAD_FIX_END)
      return CLS_FIX;
    else if (s < CTRL_AREA_END)
      return ((off % CTRL_STRIDE) == 10'h000) ? CLS_CTRL : CLS_DATA;
    else if (s < SO_POS)
      return CLS_OH;
    else if (s == SO_POS)
      return CLS_SO;
    else if (s == TAIL_DATA_POS)
      return CLS_DATA;
    else
      return CLS_FIX;
  endfunction

  // Majority of five indicator bits says stuff
  function automatic logic dsm_stuff_vote(input logic [2:0] ones);
    return ones >= CTRL_VOTE;
  endfunction

endpackage

//--- dv/dsm_framer_model.sv
// Behavioural STS-1 path framer: slot requests, row layout checks, loopback
`timescale 1ns/1ps
module dsm_framer_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic slow_in,
  input wire logic corrupt_in,
  input wire logic tx_bit_in,
  input wire logic tx_valid_in,
  input wire logic tx_pay_in,
  input wire logic tx_start_in,
  output logic req_out,
  output logic rx_bit_out,
  output logic rx_valid_out,
  output logic rx_start_out,
  output logic [3:0] so_cnt_out,
  output logic [7:0] err_out
);
  int slot;
  int row;
  int ones;
  int so_data;
  int err;
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      req_out <= 1'b0;
      rx_bit_out <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_start_out <= 1'b0;
      so_cnt_out <= 4'h0;
      err_out <= 8'h00;
      slot = 0;
      row = 9;
      ones = 0;
      so_data = 0;
      err = 0;
    end
    else
    begin
      // Slow mode asks for a slot every other cycle
      req_out <= run_in && !(slow_in && req_out);
      rx_valid_out <= tx_valid_in;
      rx_start_out <= tx_start_in;
      if (tx_valid_in)
      begin
        if (tx_start_in)
        begin
          if (row != 9)
            err++;
          so_cnt_out <= so_data[3:0];
          so_data = 0;
          slot = 0;
          row = 0;
        end
        if (tx_pay_in !== (slot >= 8))
          err++;
        if (slot >= 59 && slot <= 559 && (slot - 59) % 125 == 0)
          ones += tx_bit_in;
        if (slot == 686)
        begin
          if (ones != 0 && ones != 5)
            err++;
          if (ones == 0)
            so_data++;
        end
        rx_bit_out <= tx_bit_in ^ (corrupt_in && slot == 59);
        slot++;
        if (slot == 696)
        begin
          slot = 0;
          row++;
          ones = 0;
        end
      end
      else
        // Idle line toggles rather than holding the last bit
        rx_bit_out <= ~rx_bit_out;
      err_out <= err[7:0];
    end
  end
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the DS3 envelope mapper with framer loopback
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ds3_tx_bit_in = 1'b0;
  logic ds3_tx_valid_in = 1'b0;
  logic oh_tx_en_in = 1'b0;
  logic [1:0] oh_tx_bits_in = 2'b00;
  logic run = 1'b0, slow = 1'b0, corrupt = 1'b0, src_on = 1'b0, chk_on = 1'b0;
  logic tk, nv;
  logic ds3_tx_ready_out, sts_tx_req_in, sts_tx_bit_out, sts_tx_valid_out;
  logic sts_tx_pay_out, sts_tx_spe_start_out, tx_underrun_out;
  logic sts_rx_bit_in, sts_rx_valid_in, sts_rx_spe_start_in;
  logic ds3_rx_bit_out, ds3_rx_valid_out;
  logic [1:0] oh_rx_bits_out;
  logic [12:0] ds3_rx_env_bits_out;
  logic [3:0] so_cnt;
  logic [7:0] model_err;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int num = 1;
  int den = 1;
  int acc = 0;
  int pat = 0;
  logic sent[$];

  // ***************************************************************
  // Clock, design and far side
  // ***************************************************************
  initial
    forever #5 ref_clk_in = ~ref_clk_in;

  dsm_mapper dut (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .ds3_tx_bit_in(ds3_tx_bit_in),
    .ds3_tx_valid_in(ds3_tx_valid_in),
    .ds3_tx_ready_out(ds3_tx_ready_out),
    .sts_tx_req_in(sts_tx_req_in),
    .sts_tx_bit_out(sts_tx_bit_out),
    .sts_tx_valid_out(sts_tx_valid_out),
    .sts_tx_pay_out(sts_tx_pay_out),
    .sts_tx_spe_start_out(sts_tx_spe_start_out),
    .tx_underrun_out(tx_underrun_out),
    .oh_tx_en_in(oh_tx_en_in),
    .oh_tx_bits_in(oh_tx_bits_in),
    .sts_rx_bit_in(sts_rx_bit_in),
    .sts_rx_valid_in(sts_rx_valid_in),
    .sts_rx_spe_start_in(sts_rx_spe_start_in),
    .ds3_rx_bit_out(ds3_rx_bit_out),
    .ds3_rx_valid_out(ds3_rx_valid_out),
    .oh_rx_bits_out(oh_rx_bits_out),
    .ds3_rx_env_bits_out(ds3_rx_env_bits_out)
  );

  dsm_framer_model framer (
    .clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .run_in(run),
    .slow_in(slow),
    .corrupt_in(corrupt),
    .tx_bit_in(sts_tx_bit_out),
    .tx_valid_in(sts_tx_valid_out),
    .tx_pay_in(sts_tx_pay_out),
    .tx_start_in(sts_tx_spe_start_out),
    .req_out(sts_tx_req_in),
    .rx_bit_out(sts_rx_bit_in),
    .rx_valid_out(sts_rx_valid_in),
    .rx_start_out(sts_rx_spe_start_in),
    .so_cnt_out(so_cnt),
    .err_out(model_err)
  );

  // ***************************************************************
  // Compare, report and timeout
  // ***************************************************************
  task cmp_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task cmp_v(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t value got %0d exp %0d", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("cmp_count %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      miscompares++;
      stop_test;
    end
  end

  // Paced DS3 source, holds an offered bit until taken
  always @(posedge ref_clk_in)
  begin
    tk = ds3_tx_valid_in && ds3_tx_ready_out;
    if (tk)
      sent.push_back(ds3_tx_bit_in);
    #1;
    acc = acc + num;
    nv = ds3_tx_valid_in && !tk;
    if (!nv && src_on && acc >= den)
    begin
      acc = acc - den;
      nv = 1'b1;
      pat++;
      ds3_tx_bit_in = pat[0] ^ pat[2];
    end
    if (acc > 2 * den)
      acc = 2 * den;
    ds3_tx_valid_in = nv;
  end

  // Received DS3 stream must equal what was taken
  always @(posedge ref_clk_in)
  begin
    if (chk_on && ds3_rx_valid_out === 1'b1)
    begin
      if (sent.size() == 0)
        cmp_b(1'b1, 1'b0);
      else
        cmp_b(ds3_rx_bit_out, sent.pop_front());
    end
  end

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic restart;
    run = 1'b0;
    src_on = 1'b0;
    resetn_in = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    #1;
    cmp_b(ds3_tx_ready_out, 1'b0);
    cmp_b(sts_tx_valid_out, 1'b0);
    sent.delete();
    acc = 0;
    resetn_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    cmp_b(ds3_tx_ready_out, 1'b1);
  endtask

  task automatic envs(input int n);
    int k;
    int c;
    k = 0;
    c = 0;
    while (k < n && c < 40000)
    begin
      @(posedge ref_clk_in);
      c++;
      if (sts_tx_spe_start_out === 1'b1)
        k++;
    end
    cmp_b(k == n, 1'b1);
    repeat (5) @(posedge ref_clk_in);
    #1;
    cmp_v(13'(model_err), 13'h0000);
  endtask

  task automatic t_fill_fast;
    restart;
    corrupt = 1'b1;
    chk_on = 1'b1;
    num = 1;
    den = 1;
    src_on = 1'b1;
    repeat (20) @(posedge ref_clk_in);
    #1;
    cmp_v(13'(sent.size()), 13'h0008);
    cmp_b(ds3_tx_ready_out, 1'b0);
    run = 1'b1;
    envs(3);
    cmp_v(13'(so_cnt), 13'h0004);
    cmp_v(ds3_rx_env_bits_out, 13'h15d9);
    cmp_b(tx_underrun_out, 1'b0);
  endtask

  task automatic t_nominal;
    restart;
    corrupt = 1'b0;
    // Row data burst outruns an 8 bit FIFO at this rate, stream not compared
    chk_on = 1'b0;
    oh_tx_en_in = 1'b1;
    oh_tx_bits_in = 2'b10;
    num = 5592;
    den = 6264;
    src_on = 1'b1;
    repeat (20) @(posedge ref_clk_in);
    #1;
    run = 1'b1;
    envs(3);
    cmp_b(so_cnt >= 4'h2 && so_cnt <= 4'h4, 1'b1);
    cmp_v(ds3_rx_env_bits_out, 13'h15d5 + 13'(so_cnt));
    cmp_v(13'(oh_rx_bits_out), 13'h0002);
    cmp_b(tx_underrun_out, 1'b1);
  endtask

  task automatic t_slow;
    restart;
    oh_tx_en_in = 1'b0;
    chk_on = 1'b0;
    slow = 1'b1;
    // Sparse source keeps FIFO fill under threshold at every row start
    num = 1000;
    den = 12528;
    src_on = 1'b1;
    run = 1'b1;
    envs(3);
    cmp_v(13'(so_cnt), 13'h0002);
    cmp_v(ds3_rx_env_bits_out, 13'h15d7);
    cmp_v(13'(oh_rx_bits_out), 13'h0000);
    cmp_b(tx_underrun_out, 1'b1);
  endtask

  initial
  begin
    t_fill_fast;
    t_nominal;
    t_slow;
    stop_test;
  end
endmodule

//--- hdl/dsm_fifo.sv
// Small first-word-fall-through FIFO for the DS3 bit stream
`timescale 1ns/1ps
module dsm_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [AW:0] fill_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;
  assign out_valid_out = count_q != '0;
  assign out_data_out = mem_q[rd_q];
  assign fill_out = count_q;

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      in_ready_out <= 1'b0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      count_q <= count_d;
      in_ready_out <= count_d < (AW + 1)'(DEPTH);
    end
  end

endmodule

//--- hdl/dsm_mapper.sv
// DS3 into STS-1 envelope bit mapper and demapper with bit justification
`timescale 1ns/1ps
module dsm_mapper
  import dsm_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned FILL_W = $clog2(FIFO_DEPTH) + 1,
  parameter logic [FILL_W-1:0] FILL_THRESH = FILL_W'(FIFO_DEPTH / 2)
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic ds3_tx_bit_in,
  input wire logic ds3_tx_valid_in,
  output logic ds3_tx_ready_out,
  input wire logic sts_tx_req_in,
  output logic sts_tx_bit_out,
  output logic sts_tx_valid_out,
  output logic sts_tx_pay_out,
  output logic sts_tx_spe_start_out,
  output logic tx_underrun_out,
  input wire logic oh_tx_en_in,
  input wire logic [1:0] oh_tx_bits_in,
  input wire logic sts_rx_bit_in,
  input wire logic sts_rx_valid_in,
  input wire logic sts_rx_spe_start_in,
  output logic ds3_rx_bit_out,
  output logic ds3_rx_valid_out,
  output logic [1:0] oh_rx_bits_out,
  output logic [12:0] ds3_rx_env_bits_out
);

  // ***************************************************************
  // Input FIFO
  // ***************************************************************
  logic fifo_valid;
  logic fifo_bit;
  logic fifo_pop;
  logic [FILL_W-1:0] fifo_fill;

  dsm_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(ds3_tx_valid_in),
    .in_ready_out(ds3_tx_ready_out),
    .in_data_in(ds3_tx_bit_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_bit),
    .fill_out(fifo_fill)
  );

  // ***************************************************************
  // Mapper slot sequencing
  // ***************************************************************
  logic [9:0] tx_slot_q;
  logic [3:0] tx_row_q;
  logic so_data_q;
  logic [2:0] so_cnt_q;
  logic [2:0] so_base;
  logic [3:0] rows_left;
  logic so_dec;
  dsm_class_t tx_cls;
  dsm_class_t tx_out_cls_q;

  assign tx_cls = dsm_slot_class(tx_slot_q);
  assign so_base = (tx_row_q == '0) ? '0 : so_cnt_q;
  assign rows_left = ROWS - tx_row_q;
  // Data when FIFO is at least half full (FILL_THRESH), forced to keep 2..4 per envelope
  assign so_dec = ((so_base < SO_MAX) && (fifo_fill >= FILL_THRESH))
                  || ({1'b0, SO_MIN - so_base} >= rows_left && so_base < SO_MIN);
  assign fifo_pop = sts_tx_req_in && fifo_valid
                    && ((tx_cls == CLS_DATA) || (tx_cls == CLS_SO && so_data_q));

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_slot_q <= '0;
      tx_row_q <= '0;
    end
    else if (sts_tx_req_in)
    begin
      // Nine rows per envelope, one envelope per 9 x 696 requests
      if (tx_slot_q == SLOT_LAST)
      begin
        tx_slot_q <= '0;
        tx_row_q <= (tx_row_q == ROW_LAST) ? '0 : tx_row_q + 1'b1;
      end
      else
        tx_slot_q <= tx_slot_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      so_data_q <= 1'b0;
      so_cnt_q <= '0;
    end
    else if (sts_tx_req_in && tx_slot_q == '0)
    begin
      so_data_q <= so_dec;
      so_cnt_q <= so_base + {2'b00, so_dec};
    end
  end

  // ***************************************************************
  // Mapper output bit
  // ***************************************************************
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sts_tx_bit_out <= 1'b0;
      sts_tx_valid_out <= 1'b0;
      sts_tx_pay_out <= 1'b0;
      sts_tx_spe_start_out <= 1'b0;
      tx_underrun_out <= 1'b0;
      tx_out_cls_q <= CLS_POH;
    end
    else
    begin
      sts_tx_valid_out <= sts_tx_req_in;
      if (sts_tx_req_in)
      begin
        tx_out_cls_q <= tx_cls;
        sts_tx_spe_start_out <= (tx_slot_q == '0) && (tx_row_q == '0);
        sts_tx_pay_out <= tx_cls != CLS_POH;
        unique case (tx_cls)
          CLS_POH: sts_tx_bit_out <= FIX_VALUE;
          CLS_FIX: sts_tx_bit_out <= FIX_VALUE;
          CLS_DATA: sts_tx_bit_out <= fifo_valid ? fifo_bit : FIX_VALUE;
          CLS_CTRL: sts_tx_bit_out <= !so_data_q;
          CLS_SO: sts_tx_bit_out <= (so_data_q && fifo_valid) ? fifo_bit : FIX_VALUE;
          CLS_OH: sts_tx_bit_out <= oh_tx_en_in ? oh_tx_bits_in[tx_slot_q[0]]
                                                : FIX_VALUE;
        endcase
        if ((tx_cls == CLS_DATA || (tx_cls == CLS_SO && so_data_q)) && !fifo_valid)
          tx_underrun_out <= 1'b1;
      end
      else
        sts_tx_spe_start_out <= 1'b0;
    end
  end

  // ***************************************************************
  // Demapper
  // ***************************************************************
  logic rx_sync_q;
  logic [9:0] rx_slot_q;
  logic [9:0] rx_slot;
  logic [2:0] rx_ones_q;
  logic [12:0] rx_env_cnt_q;
  logic rx_take;
  logic rx_row_end;
  logic [3:0] rx_row_q;
  dsm_class_t rx_cls;

  assign rx_slot = sts_rx_spe_start_in ? '0 : rx_slot_q;
  assign rx_cls = dsm_slot_class(rx_slot);
  assign rx_take = sts_rx_valid_in && (rx_sync_q || sts_rx_spe_start_in)
                   && ((rx_cls == CLS_DATA)
                   || (rx_cls == CLS_SO && !dsm_stuff_vote(rx_ones_q)));
  assign rx_row_end = rx_slot == SLOT_LAST;

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rx_sync_q <= 1'b0;
      rx_slot_q <= '0;
      rx_row_q <= '0;
      rx_ones_q <= '0;
    end
    else if (sts_rx_valid_in && (rx_sync_q || sts_rx_spe_start_in))
    begin
      rx_sync_q <= 1'b1;
      rx_slot_q <= rx_row_end ? '0 : rx_slot + 1'b1;
      if (sts_rx_spe_start_in)
        rx_row_q <= '0;
      else if (rx_row_end)
        rx_row_q <= (rx_row_q == ROW_LAST) ? '0 : rx_row_q + 1'b1;
      if (rx_cls == CLS_POH)
        rx_ones_q <= '0;
      else if (rx_cls == CLS_CTRL && sts_rx_bit_in)
        rx_ones_q <= rx_ones_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ds3_rx_bit_out <= 1'b0;
      ds3_rx_valid_out <= 1'b0;
      oh_rx_bits_out <= '0;
      rx_env_cnt_q <= '0;
      ds3_rx_env_bits_out <= '0;
    end
    else
    begin
      ds3_rx_valid_out <= rx_take;
      if (rx_take)
        ds3_rx_bit_out <= sts_rx_bit_in;
      if (sts_rx_valid_in && rx_sync_q && rx_cls == CLS_OH)
        oh_rx_bits_out[rx_slot[0]] <= sts_rx_bit_in;
      if (sts_rx_valid_in && sts_rx_spe_start_in)
      begin
        ds3_rx_env_bits_out <= rx_env_cnt_q;
        rx_env_cnt_q <= '0;
      end
      else if (rx_take)
        rx_env_cnt_q <= rx_env_cnt_q + 1'b1;
    end
  end

  // ***************************************************************
  // Assertions and helper counters
  // ***************************************************************
  logic [9:0] h_fix_q;
  logic [9:0] h_dat_q;
  logic [9:0] h_ctl_q;
  logic [9:0] h_so_q;
  logic h_row_end;

  assign h_row_end = sts_tx_req_in && tx_slot_q == SLOT_LAST;

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      h_fix_q <= '0;
      h_dat_q <= '0;
      h_ctl_q <= '0;
      h_so_q <= '0;
    end
    else if (sts_tx_req_in)
    begin
      h_fix_q <= h_row_end ? '0 : h_fix_q + {9'h000, tx_cls == CLS_FIX};
      h_dat_q <= h_row_end ? '0 : h_dat_q + {9'h000, tx_cls == CLS_DATA};
      h_ctl_q <= h_row_end ? '0 : h_ctl_q + {9'h000, tx_cls == CLS_CTRL};
      h_so_q <= h_row_end ? '0 : h_so_q + {9'h000, tx_cls == CLS_SO};
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  a_poh_not_payload: assert property (
    sts_tx_valid_out && tx_out_cls_q == CLS_POH |-> !sts_tx_pay_out)
    else $error("POH slot flagged as payload");
  a_fixed_per_row: assert property (
    h_row_end |-> h_fix_q + {9'h000, tx_cls == CLS_FIX} == FIX_PER_ROW)
    else $error("Wrong fixed stuff count in row");
  a_data_per_row: assert property (
    h_row_end |-> h_dat_q == DATA_PER_ROW)
    else $error("Wrong data bit count in row");
  a_so_per_row: assert property (
    h_row_end |-> h_so_q == SO_PER_ROW)
    else $error("Wrong stuff opportunity count in row");
  a_ctrl_per_row: assert property (
    h_row_end |-> h_ctl_q == CTRL_PER_ROW)
    else $error("Wrong indicator count in row");
  a_ctrl_data_zero: assert property (
    sts_tx_req_in && tx_cls == CLS_CTRL && so_data_q |=> sts_tx_valid_out && !sts_tx_bit_out)
    else $error("Indicator not zero for data opportunity");
  a_ctrl_stuff_one: assert property (
    sts_tx_req_in && tx_cls == CLS_CTRL && !so_data_q |=> sts_tx_bit_out)
    else $error("Indicator not one for stuff opportunity");
  a_oh_unused_fixed: assert property (
    sts_tx_req_in && tx_cls == CLS_OH && !oh_tx_en_in |=> sts_tx_bit_out == FIX_VALUE)
    else $error("Unused overhead bit not fixed");
  a_so_env_range: assert property (
    sts_tx_req_in && tx_slot_q == '0 && tx_row_q == ROW_LAST
    |=> so_cnt_q >= SO_MIN && so_cnt_q <= SO_MAX)
    else $error("Envelope stuff usage out of range");
  a_rx_vote_take: assert property (
    sts_rx_valid_in && rx_sync_q && !sts_rx_spe_start_in && rx_cls == CLS_SO
    |=> ds3_rx_valid_out == (rx_ones_q < CTRL_VOTE))
    else $error("Opportunity bit misclassified");
  a_rx_fix_ignored: assert property (
    sts_rx_valid_in && (rx_cls == CLS_FIX || rx_cls == CLS_POH) |=> !ds3_rx_valid_out)
    else $error("Fixed stuff extracted as data");

  c_so_data: cover property (sts_tx_req_in && tx_cls == CLS_SO && so_data_q);
  c_so_stuff: cover property (sts_tx_req_in && tx_cls == CLS_SO && !so_data_q);
  c_env_nominal: cover property (
    sts_tx_req_in && tx_slot_q == '0 && tx_row_q == ROW_LAST ##1 so_cnt_q == SO_NOM);
  c_rx_env_nom: cover property (ds3_rx_env_bits_out == DS3_NOM_BITS);
  c_rx_last_row: cover property (sts_rx_valid_in && rx_row_q == ROW_LAST && rx_row_end);

endmodule
